/* File: bx_exec_cfg.svh */
`ifndef BX_EXEC_CFG_SVH
`define BX_EXEC_CFG_SVH
// ==========================================
// instruction encodings
`define OP_EXIT       16'h0070
`define OP_REGLINK_LO  8'h40
`define OP_IMMLINK_MID 4'h4
`define OP_IN_LO      4'hC
`define OP_OUT_LO     4'h4
// ==========================================
// level figures
`define LVL_RESET     3'h5
`define LVL_USER      3'h5
`define LVL_SVC       3'h4
// ==========================================
// invalid external address ranges
`define EXT_BAD_A_LO  7'h28
`define EXT_BAD_A_HI  7'h2F
`define EXT_BAD_B_LO  7'h49
`define EXT_BAD_B_HI  7'h4F
`define EXT_BAD_C_LO  7'h60
`define EXT_BAD_C_HI  7'h6F
`define EXT_BAD_IN    7'h78
`define EXT_BAD_OUT   7'h75
// ==========================================
// software port map
`define REG_GR_LAST   6'h27
`define REG_STATUS    6'h28
`define GR_RESET      24'h000000
`define NSI_STEP2     20'h00002
`define NSI_STEP4     20'h00004
`endif

/* File: bx_exec_pkg.sv */
package bx_exec_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_EXEC  = 3'b001,
    ST_EXTR  = 3'b010,
    ST_EXTD  = 3'b011,
    ST_GRANT = 3'b100
  } exec_state_t;
  typedef logic [23:0] greg_t;
endpackage

/* File: branch_exit_extreg_exec.sv */
// Contract
// [RQ1] count branch decrements count, branches on nonzero result
// [RQ2] zero count before run acts as 256 or 65536 iterations
// [RQ3] bit test picks one of eight bits of byte 0 or byte 1
// [RQ4] bit test branches on one, falls through on zero
// [RQ5] bit test target is next address plus signed displacement
// [RQ6] two-bit register field gets low bit forced to one
// [RQ7] register branch-link reads target, stores link, loads address register
// [RQ8] register 0 as link gives no link; as source gives no branch
// [RQ9] immediate branch-link stores link and jumps to 20-bit address
// [RQ10] exit clears entered latch and waits for priority logic group
// [RQ11] exit at level 5 raises level 4 supervisor call request
// [RQ12] masked level 4 lets execution continue at level 5
// [RQ13] program waits eight cycles after adapter clear before exit
// [RQ14] exit through interrupted level is recorded by branch trace
// [RQ15] external input loads general register from 128 registers
// [RQ16] external transfers at level 5 raise level 1 error request
// [RQ17] invalid input addresses raise level 1 request, no transfer
// [RQ18] invalid output addresses raise level 1 request, no transfer
// [RQ19] external output writes general register into three-byte register
// [RQ20] register 0 operand branches to address formed in register 0
// [RQ21] program waits eight cycles after adapter clear before reading 77/7E
// [RQ22] displacements count halfwords
//
// The plain strobed port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "bx_exec_cfg.svh"
module branch_exit_extreg_exec
  import bx_exec_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  // instruction issue
  input  wire logic        INSTR_VALID,
  input  wire logic [15:0] INSTR,
  input  wire logic [15:0] INSTR_EXT,
  output var  logic        INSTR_READY,
  output var  logic        INSTR_DONE,
  // software register port
  input  wire logic [5:0]  REG_ADDR,
  input  wire logic [23:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output var  logic [23:0] REG_RDATA,
  // external control registers
  output var  logic [6:0]  EXT_ADDR,
  output var  logic [23:0] EXT_WDATA,
  output var  logic        EXT_WR,
  output var  logic        EXT_RD,
  input  wire logic [23:0] EXT_RDATA,
  // interrupt priority logic
  output var  logic        EXIT_REQ,
  output var  logic [2:0]  EXIT_LEVEL,
  output var  logic        SUPV_CALL_REQ,
  output var  logic        L1_IOERR_REQ,
  output var  logic        L1_INVOP_REQ,
  input  wire logic        GRANT_VALID,
  input  wire logic [2:0]  GRANT_LEVEL,
  input  wire logic        GRANT_PASS,
  input  wire logic [2:0]  PASS_LEVEL,
  output var  logic [2:0]  ACTIVE_LEVEL,
  output var  logic [4:0]  ENTERED,
  // branch trace
  output var  logic        TRACE_VALID,
  output var  logic [19:0] TRACE_ADDR
);

  // ==========================================
  // helpers
  function automatic logic [5:0] gidx(input logic [2:0] lvl, input logic [2:0] r);
    gidx = {lvl - 3'h1, r};
  endfunction

  function automatic logic [19:0] tgt(input logic [19:0] nsi, input logic [5:0] t,
                                      input logic s);
    logic [19:0] off;
    off = {13'h0000, t, 1'b0};
    tgt = s ? nsi - off : nsi + off;
  endfunction

  function automatic logic in_rng(input logic [6:0] e, input logic [6:0] lo,
                                  input logic [6:0] hi);
    in_rng = (e >= lo) && (e <= hi);
  endfunction

  function automatic logic bad_ext(input logic [6:0] e, input logic is_in);
    bad_ext = in_rng(e, `EXT_BAD_A_LO, `EXT_BAD_A_HI)
            | in_rng(e, `EXT_BAD_B_LO, `EXT_BAD_B_HI)
            | in_rng(e, `EXT_BAD_C_LO, `EXT_BAD_C_HI)
            | (is_in ? (e == `EXT_BAD_IN) : (e == `EXT_BAD_OUT));
  endfunction

  // ==========================================
  // state
  exec_state_t state_q;
  exec_state_t state_d;
  greg_t       gr_q [0:39];
  logic [15:0] ir_q;
  logic [15:0] irx_q;
  logic [2:0]  lvl_q;
  logic [4:0]  ent_q;
  logic [2:0]  ext_r_q;

  // ==========================================
  // decode
  logic        is_bitbr;
  logic        is_cntbr;
  logic        is_immlink;
  logic        is_reglink;
  logic        is_exit;
  logic        is_in;
  logic        is_out;
  logic        is_io;
  logic        io_priv;
  logic        io_bad;
  logic [2:0]  odd_r;
  logic [2:0]  r1;
  logic [2:0]  r2;
  logic [6:0]  ext_e;
  logic [19:0] cur_addr;
  logic [19:0] nsi;
  logic [5:0]  cidx;
  greg_t       cval;
  logic        bbit;
  logic [15:0] cnt_d;
  logic        cnt_nz;
  logic [19:0] t_rel;
  logic [23:0] odata;

  assign is_bitbr   = ir_q[15:14] == 2'b11 && ir_q[11];
  assign is_cntbr   = ir_q[15:11] == 5'b10111 && ir_q[7];
  assign is_immlink = ir_q[15:11] == 5'b10111 && ir_q[7:4] == `OP_IMMLINK_MID;
  assign is_reglink = !ir_q[15] && !ir_q[11] && ir_q[7:0] == `OP_REGLINK_LO;
  assign is_exit = ir_q == `OP_EXIT;
  assign is_in   = !ir_q[15] && !ir_q[11] && ir_q[3:0] == `OP_IN_LO;
  assign is_out  = !ir_q[15] && !ir_q[11] && ir_q[3:0] == `OP_OUT_LO && !is_reglink;
  assign is_io   = is_in || is_out;
  assign odd_r   = {ir_q[10:9], 1'b1};  // [RQ6]
  assign r1      = ir_q[10:8];
  assign r2      = ir_q[14:12];
  assign ext_e   = {ir_q[14:12], ir_q[7:4]};
  assign cur_addr = gr_q[gidx(lvl_q, 3'h0)][19:0];
  assign nsi     = cur_addr + (is_immlink ? `NSI_STEP4 : `NSI_STEP2);
  assign cidx    = gidx(lvl_q, odd_r);
  assign cval    = gr_q[cidx];
  // bit 0 of a byte is its most significant bit
  assign bbit    = ir_q[8] ? cval[7 - {ir_q[13:12], ir_q[7]}]
                           : cval[15 - {ir_q[13:12], ir_q[7]}];  // [RQ3]
  // a zero count wraps to all ones, giving 256 or 65536 passes
  assign cnt_d   = ir_q[8] ? cval[15:0] - 16'h0001
                           : {cval[15:8] - 8'h01, cval[7:0]};  // [RQ2]
  assign cnt_nz  = ir_q[8] ? cnt_d != 16'h0000 : cnt_d[15:8] != 8'h00;  // [RQ1]
  assign t_rel   = tgt(nsi, ir_q[6:1], ir_q[0]);  // [RQ5] [RQ22]
  assign io_priv = lvl_q == `LVL_USER;
  assign io_bad  = bad_ext(ext_e, is_in);
  // register 0 operand reads the already advanced address
  assign odata   = r1 == 3'h0 ? {4'h0, nsi} : gr_q[gidx(lvl_q, r1)];  // [RQ20]

  // ==========================================
  // sequencing
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:  if (INSTR_VALID && INSTR_READY) state_d = ST_EXEC;
      ST_EXEC:
      begin
        if (is_exit)
          state_d = ST_GRANT;  // [RQ10]
        else if (is_io && !io_priv && !io_bad)
          state_d = is_in ? ST_EXTR : ST_IDLE;
        else
          state_d = ST_IDLE;
      end
      ST_EXTR:  state_d = ST_EXTD;
      ST_EXTD:  state_d = ST_IDLE;
      ST_GRANT: if (GRANT_VALID) state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      state_q     <= ST_IDLE;
      INSTR_READY <= 1'b0;
      INSTR_DONE  <= 1'b0;
    end
    else
    begin
      state_q     <= state_d;
      INSTR_READY <= state_d == ST_IDLE && !(state_q == ST_IDLE && INSTR_VALID && INSTR_READY);
      INSTR_DONE  <= state_q != ST_IDLE && state_d == ST_IDLE;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      ir_q  <= 16'h0000;
      irx_q <= 16'h0000;
    end
    else if (state_q == ST_IDLE && INSTR_VALID && INSTR_READY)
    begin
      ir_q  <= INSTR;
      irx_q <= INSTR_EXT;
    end
  end

  // ==========================================
  // general register groups
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      for (int i = 0; i < 40; i++)
        gr_q[i] <= `GR_RESET;
    end
    else if (state_q == ST_EXEC)
    begin
      gr_q[gidx(lvl_q, 3'h0)] <= {4'h0, nsi};
      if (is_bitbr && bbit)
        gr_q[gidx(lvl_q, 3'h0)] <= {4'h0, t_rel};  // [RQ4]
      if (is_cntbr)
      begin
        gr_q[cidx] <= {cval[23:16], cnt_d};  // [RQ1]
        if (cnt_nz)
          gr_q[gidx(lvl_q, 3'h0)] <= {4'h0, t_rel};
      end
      if (is_reglink)
      begin
        // target is read before the link lands, so r1 == r2 still works
        if (r2 != 3'h0)
          gr_q[gidx(lvl_q, 3'h0)] <= {4'h0, gr_q[gidx(lvl_q, r2)][19:0]};  // [RQ7] [RQ8]
        if (r1 != 3'h0)
          gr_q[gidx(lvl_q, r1)] <= {4'h0, nsi};  // [RQ7] [RQ8]
      end
      if (is_immlink)
      begin
        gr_q[gidx(lvl_q, 3'h0)] <= {4'h0, ir_q[3:0], irx_q};  // [RQ9]
        if (r1 != 3'h0)
          gr_q[gidx(lvl_q, r1)] <= {4'h0, nsi};  // [RQ9]
      end
    end
    else if (state_q == ST_EXTD)
      gr_q[gidx(lvl_q, ext_r_q)] <= EXT_RDATA;  // [RQ15] [RQ20]
    else if (REG_WR && REG_ADDR <= `REG_GR_LAST)
      gr_q[REG_ADDR] <= REG_WDATA;
  end

  // ==========================================
  // external register transfers
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      EXT_ADDR     <= 7'h00;
      EXT_WDATA    <= 24'h000000;
      EXT_WR       <= 1'b0;
      EXT_RD       <= 1'b0;
      ext_r_q      <= 3'h0;
      L1_IOERR_REQ <= 1'b0;
      L1_INVOP_REQ <= 1'b0;
    end
    else
    begin
      EXT_WR       <= 1'b0;
      EXT_RD       <= 1'b0;
      L1_IOERR_REQ <= 1'b0;
      L1_INVOP_REQ <= 1'b0;
      if (state_q == ST_EXEC && is_io)
      begin
        if (io_priv)
          L1_IOERR_REQ <= 1'b1;  // [RQ16]
        else if (io_bad)
          L1_INVOP_REQ <= 1'b1;  // [RQ17] [RQ18]
        else
        begin
          EXT_ADDR  <= ext_e;
          EXT_WDATA <= odata;  // [RQ19]
          EXT_WR    <= is_out;  // [RQ19]
          EXT_RD    <= is_in;  // [RQ15]
          ext_r_q   <= r1;
        end
      end
    end
  end

  // ==========================================
  // exit and level change
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      lvl_q       <= `LVL_RESET;
      ent_q       <= 5'h00;
      EXIT_REQ    <= 1'b0;
      EXIT_LEVEL  <= `LVL_RESET;
      SUPV_CALL_REQ <= 1'b0;
      TRACE_VALID <= 1'b0;
      TRACE_ADDR  <= 20'h00000;
    end
    else
    begin
      EXIT_REQ    <= 1'b0;
      SUPV_CALL_REQ <= 1'b0;
      TRACE_VALID <= 1'b0;
      if (state_q == ST_EXEC && is_exit)
      begin
        EXIT_REQ          <= 1'b1;  // [RQ10]
        EXIT_LEVEL        <= lvl_q;
        ent_q[lvl_q - 3'h1] <= 1'b0;  // [RQ10]
        SUPV_CALL_REQ     <= lvl_q == `LVL_USER;  // [RQ11]
      end
      if (state_q == ST_GRANT && GRANT_VALID)
      begin
        // a masked level 4 comes back here as level 5
        lvl_q <= GRANT_LEVEL;  // [RQ10] [RQ12]
        if (GRANT_LEVEL != `LVL_USER)
          ent_q[GRANT_LEVEL - 3'h1] <= 1'b1;
        if (GRANT_PASS)
        begin
          TRACE_VALID <= 1'b1;  // [RQ14]
          TRACE_ADDR  <= gr_q[gidx(PASS_LEVEL, 3'h0)][19:0];  // [RQ14]
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      ACTIVE_LEVEL <= `LVL_RESET;
      ENTERED      <= 5'h00;
    end
    else
    begin
      ACTIVE_LEVEL <= lvl_q;
      ENTERED      <= ent_q;
    end
  end

  // ==========================================
  // software read port
  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      REG_RDATA <= 24'h000000;
    else if (REG_RD && REG_ADDR <= `REG_GR_LAST)
      REG_RDATA <= gr_q[REG_ADDR];
    else if (REG_RD && REG_ADDR == `REG_STATUS)
      REG_RDATA <= {13'h0000, state_q, ent_q, lvl_q};
    else
      REG_RDATA <= 24'h000000;
  end

  // ==========================================
  // checks
  logic ex_q;
  assign ex_q = state_q == ST_EXEC;

  chk_count_wrap: assert property (  // [RQ2]
    @(posedge CLK_SYS) disable iff (RST)
    ex_q && is_cntbr && !ir_q[8] && cval[15:8] == 8'h00
    |=> gr_q[$past(cidx)][15:8] == 8'hFF)
    else $error("count of zero did not wrap");

  chk_bit_fallthru: assert property (  // [RQ4]
    @(posedge CLK_SYS) disable iff (RST)
    ex_q && is_bitbr && !bbit
    |=> gr_q[gidx(lvl_q, 3'h0)][19:0] == $past(nsi))
    else $error("bit test took branch on zero");

  chk_priv_level: assert property (  // [RQ16]
    @(posedge CLK_SYS) disable iff (RST)
    ex_q && is_io && io_priv
    |=> L1_IOERR_REQ && !EXT_RD && !EXT_WR)
    else $error("level 5 transfer not refused");

  chk_bad_addr: assert property (  // [RQ17]
    @(posedge CLK_SYS) disable iff (RST)
    ex_q && is_io && !io_priv && io_bad
    |=> L1_INVOP_REQ && !EXT_RD && !EXT_WR ##1 !EXT_RD)
    else $error("invalid address not refused");

  chk_out_data: assert property (  // [RQ19]
    @(posedge CLK_SYS) disable iff (RST)
    ex_q && is_out && !io_priv && !io_bad
    |=> EXT_WR && EXT_WDATA == $past(odata) && EXT_ADDR == $past(ext_e))
    else $error("output transfer wrong");

  chk_in_load: assert property (  // [RQ15]
    @(posedge CLK_SYS) disable iff (RST)
    EXT_RD |-> ##2 gr_q[gidx(lvl_q, $past(ext_r_q, 2))] == $past(EXT_RDATA))
    else $error("input data not loaded");

  chk_exit_svc: assert property (  // [RQ11]
    @(posedge CLK_SYS) disable iff (RST)
    ex_q && is_exit
    |=> EXIT_REQ && SUPV_CALL_REQ == ($past(lvl_q) == `LVL_USER) && state_q == ST_GRANT)
    else $error("exit request wrong");

  chk_grant_hold: assert property (  // [RQ10]
    @(posedge CLK_SYS) disable iff (RST)
    state_q == ST_GRANT && !GRANT_VALID |=> state_q == ST_GRANT && !INSTR_READY)
    else $error("left exit wait without grant");

  chk_reglink_nobr: assert property (  // [RQ8]
    @(posedge CLK_SYS) disable iff (RST)
    ex_q && is_reglink && r2 == 3'h0
    |=> gr_q[gidx(lvl_q, 3'h0)][19:0] == $past(nsi))
    else $error("register 0 source branched");

endmodule // branch_exit_extreg_exec
`default_nettype wire

/* File: ctl_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module ctl_partner (
  // clock
  input  wire logic        clk,
  // external control registers
  input  wire logic [6:0]  ext_addr,
  input  wire logic [23:0] ext_wdata,
  input  wire logic        ext_wr,
  input  wire logic        ext_rd,
  output var  logic [23:0] ext_rdata,
  // priority decision set by the bench
  input  wire logic        exit_req,
  input  wire logic [1:0]  dly,
  input  wire logic [2:0]  nxt_lvl,
  input  wire logic        pass_en,
  input  wire logic [2:0]  pass_lvl,
  output var  logic        grant_valid,
  output var  logic [2:0]  grant_level,
  output var  logic        grant_pass,
  output var  logic [2:0]  pass_level
);
  logic [23:0] regs_q [128];
  logic [1:0]  wait_q;
  logic        busy_q;
  initial
  begin
    foreach (regs_q[k]) regs_q[k] = 24'h000000;
    {ext_rdata, grant_valid, grant_level, grant_pass, pass_level, wait_q, busy_q} = '0;
  end
  // ========
  // register file; idle read data toggles so stale values never pass
  always @(posedge clk)
  begin
    if (ext_wr === 1'b1) regs_q[ext_addr] <= ext_wdata;
    ext_rdata <= (ext_rd === 1'b1) ? regs_q[ext_addr] : ~ext_rdata;
  end
  // ========
  // grant after a chosen delay; level fields toggle outside the pulse
  always @(posedge clk)
  begin
    grant_valid <= 1'b0;
    grant_level <= ~grant_level;
    grant_pass <= ~grant_pass;
    pass_level <= ~pass_level;
    if (exit_req === 1'b1)
    begin
      busy_q <= 1'b1;
      wait_q <= dly;
    end
    else if (busy_q && wait_q != 2'h0)
      wait_q <= wait_q - 2'h1;
    else if (busy_q)
    begin
      {grant_valid, grant_level, grant_pass, pass_level} <= {1'b1, nxt_lvl, pass_en, pass_lvl};
      busy_q <= 1'b0;
    end
  end
endmodule // ctl_partner
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
  import bx_exec_pkg::*;
;
  logic CLK_SYS = 0, RST = 1, INSTR_VALID = 0, REG_WR = 0, REG_RD = 0, pas = 0;
  logic [15:0] INSTR = 16'h0000, INSTR_EXT = 16'h0000;
  logic [5:0]  REG_ADDR = 6'h00;
  greg_t       REG_WDATA = 24'h000000, REG_RDATA, EXT_WDATA, EXT_RDATA;
  logic [6:0]  EXT_ADDR;
  logic [2:0]  EXIT_LEVEL, GRANT_LEVEL, PASS_LEVEL, ACTIVE_LEVEL, nxt = 3'h4;
  logic [4:0]  ENTERED, ent = 5'h00;
  logic [19:0] TRACE_ADDR, tra;
  logic [1:0]  dly = 2'h0;
  logic INSTR_READY, INSTR_DONE, EXT_WR, EXT_RD, EXIT_REQ, SUPV_CALL_REQ, L1_IOERR_REQ, L1_INVOP_REQ;
  logic GRANT_VALID, GRANT_PASS, TRACE_VALID;
  int fail_count = 0, n_compared = 0, n_wr = 0, n_rd = 0, n_svc = 0, n_io = 0, n_inv = 0, n_tr = 0, n_ex = 0;
  int lv = 5;
  integer seed = 32'h1558525b;

  branch_exit_extreg_exec branch_exit_extreg_exec_i (.CLK_SYS, .RST, .INSTR_VALID, .INSTR, .INSTR_EXT,
    .INSTR_READY, .INSTR_DONE, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .EXT_ADDR,
    .EXT_WDATA, .EXT_WR, .EXT_RD, .EXT_RDATA, .EXIT_REQ, .EXIT_LEVEL, .SUPV_CALL_REQ, .L1_IOERR_REQ,
    .L1_INVOP_REQ, .GRANT_VALID, .GRANT_LEVEL, .GRANT_PASS, .PASS_LEVEL, .ACTIVE_LEVEL, .ENTERED,
    .TRACE_VALID, .TRACE_ADDR);
  ctl_partner ctl_partner_i (.clk(CLK_SYS), .ext_addr(EXT_ADDR), .ext_wdata(EXT_WDATA), .ext_wr(EXT_WR),
    .ext_rd(EXT_RD), .ext_rdata(EXT_RDATA), .exit_req(EXIT_REQ), .dly(dly), .nxt_lvl(nxt), .pass_en(pas),
    .pass_lvl(3'h5), .grant_valid(GRANT_VALID), .grant_level(GRANT_LEVEL), .grant_pass(GRANT_PASS),
    .pass_level(PASS_LEVEL));

  always #12.5 CLK_SYS = ~CLK_SYS;
  // ========
  // pulse counters
  always @(posedge CLK_SYS)
  begin
    n_wr += (EXT_WR === 1'b1);
    n_rd += (EXT_RD === 1'b1);
    n_svc += (SUPV_CALL_REQ === 1'b1);
    n_ex += (EXIT_REQ === 1'b1);
    n_io += (L1_IOERR_REQ === 1'b1);
    n_inv += (L1_INVOP_REQ === 1'b1);
    n_tr += (TRACE_VALID === 1'b1);
    if (TRACE_VALID === 1'b1) tra = TRACE_ADDR;
  end
  // ========
  // helpers
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, greg_t e, greg_t g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [5:0] a, greg_t d);
    @(posedge CLK_SYS);
    {REG_WR, REG_ADDR, REG_WDATA} <= {1'b1, a, d};
    @(posedge CLK_SYS);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(logic [5:0] a, output greg_t d);
    @(posedge CLK_SYS);
    {REG_RD, REG_ADDR} <= {1'b1, a};
    @(posedge CLK_SYS);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask
  task automatic ex(logic [15:0] i, logic [15:0] e = 16'h0000);
    int n = 0;
    @(posedge CLK_SYS);
    {INSTR_VALID, INSTR, INSTR_EXT} <= {1'b1, i, e};
    #1;
    while (INSTR_READY !== 1'b1 && n < 50)
    begin
      @(posedge CLK_SYS);
      #1 n++;
    end
    @(posedge CLK_SYS);
    INSTR_VALID <= 1'b0;
    n = 0;
    do
    begin
      @(posedge CLK_SYS);
      #1 n++;
    end
    while (INSTR_DONE !== 1'b1 && n < 99);
    chk("done", 24'h000001, {23'h000000, INSTR_DONE});
    chk("ready", 24'h000001, {23'h000000, INSTR_READY});
    @(posedge CLK_SYS);
    #1;
  endtask
  task automatic io(logic o, logic [6:0] e, logic [2:0] r);
    ex({1'b0, e[6:4], 1'b0, r, e[3:0], o ? 4'h4 : 4'hC});
  endtask
  function automatic logic [5:0] ga(logic [2:0] r);
    return 6'((lv - 1) * 8 + r);
  endfunction
  function automatic logic [19:0] rel(logic [19:0] a, logic [5:0] d, logic s);
    return s ? a + 20'h00002 - {d, 1'b0} : a + 20'h00002 + {d, 1'b0};
  endfunction
  // no adapter transfers are issued, so the settle gap before exit holds
  task automatic go(logic [2:0] nx, logic p);
    int s0 = n_svc, t0 = n_tr, e0 = n_ex;
    greg_t g;
    dly <= 2'($random(seed));
    {nxt, pas} <= {nx, p};
    ex(16'h0070);
    chk("exit level", 24'(lv), {21'h000000, EXIT_LEVEL});
    chk("svc req", 24'(lv == 5), 24'(n_svc - s0));
    chk("trace", 24'(p), 24'(n_tr - t0));
    chk("exit req", 24'h000001, 24'(n_ex - e0));
    ent[lv - 1] = 1'b0;
    if (nx != 3'h5) ent[nx - 1] = 1'b1;
    lv = nx;
    rd(6'h28, g);
    chk("status", {13'h0000, 3'h0, ent, nx}, g);
    chk("active level", {21'h000000, nx}, {21'h000000, ACTIVE_LEVEL});
    chk("entered", {19'h00000, ent}, {19'h00000, ENTERED});
  endtask
  // ========
  // main sequence
  initial
  begin : main
    greg_t v, t, g;
    logic [19:0] ia;
    logic [15:0] c, i;
    logic [5:0] d;
    logic [2:0] m, r, r2;
    logic nn, s, hit;
    logic [6:0] ok [8] = '{7'h00, 7'h27, 7'h30, 7'h48, 7'h50, 7'h5F, 7'h70, 7'h7F};
    logic [6:0] bi [7] = '{7'h28, 7'h2F, 7'h49, 7'h4F, 7'h60, 7'h6F, 7'h78};
    logic [6:0] bo [7] = '{7'h28, 7'h2F, 7'h49, 7'h4F, 7'h60, 7'h6F, 7'h75};
    logic [2:0] l1 [6] = '{3'h3, 3'h0, 3'h2, 3'h4, 3'h3, 3'h0};
    logic [2:0] l2 [6] = '{3'h5, 3'h6, 3'h0, 3'h4, 3'h0, 3'h0};
    int w0, w1;
    repeat (10) @(posedge CLK_SYS);
    RST <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
    for (int k = 0; k < 14; k++)
    begin
      {v, ia, d, s, r} = 54'({$random(seed), $random(seed)});
      {ia[0], r[0], m, nn} = {1'b0, 1'b1, 3'(k), k[0]};
      if (k < 8)
      begin
        v[nn ? 7 - m : 15 - m] = k[1];
        {hit, t} = {k[1], v};
        i = {2'b11, m[2:1], 1'b1, r[2:1], nn, m[0], d, s};
      end
      else
      begin
        c = (k < 10) ? 16'h0000 : (k < 12) ? 16'h0001 : v[15:0];
        v = nn ? {v[23:16], c} : {v[23:16], c[7:0], v[7:0]};
        t = nn ? {v[23:16], c - 16'h0001} : {v[23:16], c[7:0] - 8'h01, v[7:0]};
        hit = nn ? (c != 16'h0001) : (c[7:0] != 8'h01);
        i = {5'b10111, r[2:1], nn, 1'b1, d, s};
      end
      wr(ga(3'h0), {4'h0, ia});
      wr(ga(r), v);
      ex(i);
      rd(ga(3'h0), g);
      chk("branch addr", {4'h0, hit ? rel(ia, d, s) : ia + 20'h00002}, g);
      rd(ga(r), g);
      chk("tested reg", t, g);
    end
    $display("test branch done");
    for (int k = 0; k < 6; k++)
    begin
      {t, ia} = 44'({$random(seed), $random(seed)});
      {ia[0], r, r2} = {1'b0, l1[k], l2[k]};
      wr(ga(r2), t);
      wr(ga(3'h0), {4'h0, ia});
      if (k < 4) ex({1'b0, r2, 1'b0, r, 8'h40});
      else ex({5'b10111, r, 4'b0100, t[19:16]}, t[15:0]);
      rd(ga(3'h0), g);
      chk("link addr", {4'h0, (k > 3 || r2 != 3'h0) ? t[19:0] : ia + 20'h00002}, g);
      rd(ga(r), g);
      if (r != 3'h0) chk("link reg", {4'h0, ia + (k > 3 ? 20'h00004 : 20'h00002)}, g);
    end
    $display("test link done");
    go(3'h4, 1'b0);
    for (int k = 0; k < 8; k++)
    begin
      v = 24'($random(seed));
      {r, r2} = {3'(k % 7 + 1), 3'((k + 1) % 7 + 1)};
      wr(ga(r), v);
      {w0, w1} = {n_wr, n_rd};
      io(1'b1, ok[k], r);
      chk("out addr", {17'h00000, ok[k]}, {17'h00000, EXT_ADDR});
      chk("out data", v, EXT_WDATA);
      io(1'b0, ok[k], r2);
      rd(ga(r2), g);
      chk("in data", v, g);
      chk("strobes", 24'h000002, 24'(n_wr - w0 + n_rd - w1));
    end
    for (int k = 0; k < 7; k++)
    begin
      {w0, w1} = {n_inv, n_wr + n_rd};
      io(1'b0, bi[k], 3'h1);
      io(1'b1, bo[k], 3'h1);
      chk("bad count", 24'h000002, 24'(n_inv - w0));
      chk("bad strobe", 24'h000000, 24'(n_wr + n_rd - w1));
      rd(ga(3'h1), g);
      chk("bad keep", v, g);
    end
    w1 = n_wr + n_rd;
    io(1'b1, 7'h78, 3'h3);
    io(1'b0, 7'h75, 3'h2);
    chk("edge strobes", 24'h000002, 24'(n_wr + n_rd - w1));
    ia = {20'($random(seed)) & 20'hFFFFE};
    wr(ga(3'h1), {4'h0, ia});
    io(1'b1, 7'h30, 3'h1);
    io(1'b0, 7'h30, 3'h0);
    rd(ga(3'h0), g);
    chk("in to addr", {4'h0, ia}, g);
    io(1'b1, 7'h30, 3'h0);
    chk("out r0", {4'h0, ia + 20'h00002}, EXT_WDATA);
    $display("test external done");
    wr(6'h20, {4'h0, ~ia});
    go(3'h3, 1'b1);
    chk("trace addr", {4'h0, ~ia}, {4'h0, tra});
    go(3'h5, 1'b0);
    go(3'h5, 1'b0);
    {w0, w1} = {n_io, n_wr + n_rd};
    io(1'b0, 7'h30, 3'h3);
    io(1'b1, 7'h30, 3'h3);
    chk("priv error", 24'h000002, 24'(n_io - w0));
    chk("priv strobe", 24'h000000, 24'(n_wr + n_rd - w1));
    $display("test exit done");
    test_done();
  end
  initial
  begin
    #2000000;
    fail_count++;
    $display("ERROR watchdog expected finish got timeout");
    test_done();
  end
endmodule // testbench
`default_nettype wire
